// file: design/ppbs_pkg.sv
// ppbs_pkg: register map, field positions and reset values of the parallel slave buffer status block
// assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses
package ppbs_pkg;
  localparam int NUM_BUF = 4;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_BUFFER_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_IN_DATA0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_OUT_DATA0 = 8'h20;
  localparam int POS_INPUT_ALL_FULL = 15;
  localparam int POS_INPUT_OVERFLOW = 14;
  localparam int POS_INPUT_FULL_LO = 8;
  localparam int POS_OUTPUT_ALL_EMPTY = 7;
  localparam int POS_OUTPUT_UNDERFLOW = 6;
  localparam int POS_OUTPUT_EMPTY_LO = 0;
  localparam int POS_CTRL_SLAVE_MODE = 0;
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_UNDERFLOW = 1;
  localparam int IRQ_INPUT_ALL_FULL = 2;
  localparam int IRQ_OUTPUT_ALL_EMPTY = 3;
  localparam int IRQ_W = 4;
  localparam logic [NUM_BUF-1:0] RST_INPUT_FULL = 4'h0;
  localparam logic [NUM_BUF-1:0] RST_OUTPUT_EMPTY = 4'hF;
  localparam logic RST_SLAVE_MODE = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ppbs_pkg

// file: design/ppbs_byte_buffer.sv
// ppbs_byte_buffer: one byte buffer with an occupied flag
// assumes single-cycle fill and drain strobes on sys_clk; fill wins over a simultaneous drain
`timescale 1ns/10ps
`default_nettype none
module ppbs_byte_buffer #(
  // occupied state out of reset
  parameter logic RST_OCCUPIED = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstSync_n,
  // fill side
  input wire logic fillStb,
  input wire logic [7:0] fillData,
  // drain side
  input wire logic drainStb,
  // state
  output logic [7:0] data,
  output logic occupied
);
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      data <= 8'h00;
      occupied <= RST_OCCUPIED;
    end
    else
    begin
      if (fillStb)
      begin
        data <= fillData;
      end
      occupied <= fillStb | (occupied & ~drainStb);
    end
  end
endmodule // ppbs_byte_buffer
`default_nettype wire

// file: design/ppbs_top.sv
// ppbs_top: status logic for the slave side of a byte-wide parallel port
// assumes host strobes arrive asynchronous on pins; software on AXI4-Lite at sys_clk
`timescale 1ns/10ps
`default_nettype none
// Operation
// [R01] four input buffers each with full flag
// [R02] software read of input buffer clears full
// [R03] all-full only when every input full
// [R04] host write to full input sets overflow
// [R05] four output buffers, software write clears empty
// [R06] empty reads zero while host not taken
// [R07] all-empty only when every output empty
// [R08] host read of empty output sets underflow
// [R09] status tracked only in slave mode
// [R10] unused status bits read zero, ignore writes
// [R11] reset: full and errors zero, empties one
module ppbs_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ppbs_pkg::ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ppbs_pkg::ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // host pins
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [1:0] hostAddr,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  // interrupt
  output logic irq
);
  import ppbs_pkg::*;

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rstPipe;
  logic rstSync_n;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstPipe <= 2'h0;
    end
    else
    begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe[1];

  logic [11:0] pinMeta;
  logic [11:0] pinSync;
  logic wrLast;
  logic rdLast;
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      pinMeta <= 12'h000;
      pinSync <= 12'h000;
      wrLast <= 1'b0;
      rdLast <= 1'b0;
    end
    else
    begin
      pinMeta <= {hostWrite, hostRead, hostAddr, hostDataIn};
      pinSync <= pinMeta;
      wrLast <= pinSync[11];
      rdLast <= pinSync[10];
    end
  end
  wire hostWrStb = pinSync[11] & ~wrLast;
  wire hostRdStb = pinSync[10] & ~rdLast;
  wire [1:0] hostSel = pinSync[9:8];
  wire [7:0] hostByte = pinSync[7:0];

  // ----------------------------------------
  // register bus decode
  // ----------------------------------------
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic slaveMode;
  logic ovfErr;
  logic unfErr;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic [NUM_BUF-1:0] inFull;
  logic [NUM_BUF-1:0] outFull;
  logic [7:0] inData [NUM_BUF];
  logic [7:0] outData [NUM_BUF];

  wire wrFire = awHeld & wHeld & ~s_axi_bvalid;
  wire rdFire = s_axi_arvalid & s_axi_arready;
  wire wrStatus = wrFire & (awAddr == OFF_BUFFER_STATUS);
  wire wrCtrl = wrFire & (awAddr == OFF_CONTROL) & wStrb[0];
  wire wrMask = wrFire & (awAddr == OFF_IRQ_MASK) & wStrb[0];
  wire wrOutRange = wrFire & (awAddr[ADDR_W-1:4] == OFF_OUT_DATA0[ADDR_W-1:4]);
  wire rdInRange = rdFire & (s_axi_araddr[ADDR_W-1:4] == OFF_IN_DATA0[ADDR_W-1:4]);
  wire rdIrqStat = rdFire & (s_axi_araddr == OFF_IRQ_STATUS);
  wire wrMapped = (awAddr == OFF_BUFFER_STATUS) | (awAddr == OFF_CONTROL) |
                  (awAddr == OFF_IRQ_STATUS) | (awAddr == OFF_IRQ_MASK) |
                  (awAddr[ADDR_W-1:4] == OFF_OUT_DATA0[ADDR_W-1:4]) |
                  (awAddr[ADDR_W-1:4] == OFF_IN_DATA0[ADDR_W-1:4]);
  wire [1:0] wrIdx = awAddr[3:2];
  wire [1:0] rdIdx = s_axi_araddr[3:2];

  // ----------------------------------------
  // buffer flags and events
  // ----------------------------------------
  wire [NUM_BUF-1:0] outEmpty = ~outFull;
  wire allFull = &inFull; // [R03]
  wire allEmpty = &outEmpty; // [R07]
  wire hostOvf = slaveMode & hostWrStb & inFull[hostSel]; // [R04]
  wire hostUnf = slaveMode & hostRdStb & ~outFull[hostSel]; // [R08]
  wire swClrOvf = wrStatus & wStrb[1] & ~wData[POS_INPUT_OVERFLOW];
  wire swClrUnf = wrStatus & wStrb[0] & ~wData[POS_OUTPUT_UNDERFLOW];
  wire [31:0] statusWord = {16'h0000, allFull, ovfErr, 2'b00, inFull,
                            allEmpty, unfErr, 2'b00, outEmpty}; // [R10]
  wire [IRQ_W-1:0] irqEvents = {allFull, allEmpty, hostUnf, hostOvf};
  wire [IRQ_W-1:0] irqEventsOrdered;
  assign irqEventsOrdered[IRQ_OVERFLOW] = hostOvf;
  assign irqEventsOrdered[IRQ_UNDERFLOW] = hostUnf;
  assign irqEventsOrdered[IRQ_INPUT_ALL_FULL] = irqEvents[3] & slaveMode;
  assign irqEventsOrdered[IRQ_OUTPUT_ALL_EMPTY] = irqEvents[2] & slaveMode;

  genvar g;
  generate
    for (g = 0; g < NUM_BUF; g++)
    begin : gBuf
      wire inFill = slaveMode & hostWrStb & (hostSel == g) & ~inFull[g]; // [R01] [R09]
      wire inDrain = rdInRange & (rdIdx == g); // [R02]
      wire outFill = wrOutRange & (wrIdx == g) & wStrb[0]; // [R05]
      wire outDrain = slaveMode & hostRdStb & (hostSel == g); // [R06]
      ppbs_byte_buffer #(.RST_OCCUPIED(RST_INPUT_FULL[g])) uIn (
        .sys_clk(sys_clk),
        .rstSync_n(rstSync_n),
        .fillStb(inFill),
        .fillData(hostByte),
        .drainStb(inDrain),
        .data(inData[g]),
        .occupied(inFull[g])
      );
      ppbs_byte_buffer #(.RST_OCCUPIED(~RST_OUTPUT_EMPTY[g])) uOut (
        .sys_clk(sys_clk),
        .rstSync_n(rstSync_n),
        .fillStb(outFill),
        .fillData(wData[7:0]),
        .drainStb(outDrain),
        .data(outData[g]),
        .occupied(outFull[g])
      );
    end
  endgenerate

  wire [31:0] rdMux =
    (s_axi_araddr == OFF_BUFFER_STATUS) ? statusWord :
    (s_axi_araddr == OFF_CONTROL) ? {31'h0, slaveMode} :
    (s_axi_araddr == OFF_IRQ_STATUS) ? {28'h0, irqStatus} :
    (s_axi_araddr == OFF_IRQ_MASK) ? {28'h0, irqMask} :
    (s_axi_araddr[ADDR_W-1:4] == OFF_IN_DATA0[ADDR_W-1:4]) ? {24'h0, inData[rdIdx]} :
    (s_axi_araddr[ADDR_W-1:4] == OFF_OUT_DATA0[ADDR_W-1:4]) ? {24'h0, outData[rdIdx]} :
    32'h0000_0000;
  wire rdMapped = (s_axi_araddr == OFF_BUFFER_STATUS) | (s_axi_araddr == OFF_CONTROL) |
                  (s_axi_araddr == OFF_IRQ_STATUS) | (s_axi_araddr == OFF_IRQ_MASK) |
                  (s_axi_araddr[ADDR_W-1:4] == OFF_IN_DATA0[ADDR_W-1:4]) |
                  (s_axi_araddr[ADDR_W-1:4] == OFF_OUT_DATA0[ADDR_W-1:4]);
  wire [IRQ_W-1:0] next_irqStatus = irqEventsOrdered | (irqStatus & {IRQ_W{~rdIrqStat}});
  wire next_ovfErr = hostOvf | (ovfErr & ~swClrOvf); // [R04]
  wire next_unfErr = hostUnf | (unfErr & ~swClrUnf); // [R08]

  // ----------------------------------------
  // error flags, control, interrupt
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      ovfErr <= 1'b0; // [R11]
      unfErr <= 1'b0; // [R11]
      slaveMode <= RST_SLAVE_MODE;
      irqStatus <= 4'h0;
      irqMask <= 4'h0;
      irq <= 1'b0;
      hostDataOut <= 8'h00;
    end
    else
    begin
      ovfErr <= next_ovfErr;
      unfErr <= next_unfErr;
      slaveMode <= wrCtrl ? wData[POS_CTRL_SLAVE_MODE] : slaveMode;
      irqStatus <= next_irqStatus;
      irqMask <= wrMask ? wData[IRQ_W-1:0] : irqMask;
      irq <= |(next_irqStatus & irqMask);
      hostDataOut <= hostRdStb ? outData[hostSel] : hostDataOut;
    end
  end

  // ----------------------------------------
  // axi4-lite write address and write data
  // ----------------------------------------
  wire bDone = s_axi_bvalid & s_axi_bready;

  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      else if (bDone)
      begin
        awHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid & s_axi_wready)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      else if (bDone)
      begin
        wHeld <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite write response
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bDone)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read address and read data
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rdFire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // ppbs_top
`default_nettype wire

// file: sim/ppbs_top_chk.sv
// ppbs_top_chk: register bus assertions and an interrupt cover for ppbs_top
// assumes it is bound onto ppbs_top and that nrst low resets the block
`timescale 1ns/10ps
`default_nettype none
module ppbs_top_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // read side
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ppbs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // write response and interrupt
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic irq
);
  import ppbs_pkg::*;
  logic [ADDR_W-1:0] rdAddr;
  logic stat;
  assign stat = s_axi_rvalid && rdAddr == OFF_BUFFER_STATUS;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      rdAddr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rdAddr <= s_axi_araddr;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_hi_zero; stat |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
  property p_gap_zero; stat |-> {s_axi_rdata[13:12], s_axi_rdata[5:4]} == 4'h0; endproperty
  a_gap_zero: assert property (p_gap_zero) else $error("unused bits set");
  property p_all_full; stat |-> s_axi_rdata[15] == &s_axi_rdata[11:8]; endproperty
  a_all_full: assert property (p_all_full) else $error("all-full wrong");
  property p_all_empty; stat |-> s_axi_rdata[7] == &s_axi_rdata[3:0]; endproperty
  a_all_empty: assert property (p_all_empty) else $error("all-empty wrong");
  property p_rans; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone) else $error("read data repeated");
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write response repeated");
  property p_rerr; s_axi_rvalid && rdAddr >= 8'h30 |-> s_axi_rresp == RESP_SLVERR && !(|s_axi_rdata);
  endproperty
  a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
  c_full: cover property (stat && s_axi_rdata[15]);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_irq: cover property ($rose(irq));
endmodule // ppbs_top_chk
bind ppbs_top ppbs_top_chk u_chk (.sys_clk, .nrst, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .s_axi_bvalid, .s_axi_bready, .irq);
`default_nettype wire

// file: sim/ppbs_host_model.sv
// ppbs_host_model: external host on the byte-wide parallel pins
// assumes strobes are sampled on sys_clk and take effect three clocks after they rise
`timescale 1ns/10ps
`default_nettype none
module ppbs_host_model (
  // clock
  input wire logic sys_clk,
  // host pins
  output logic hostWrite,
  output logic hostRead,
  output logic [1:0] hostAddr,
  output logic [7:0] hostDataIn,
  input wire logic [7:0] hostDataOut
);
  initial
  begin
    hostWrite = 1'b0;
    hostRead = 1'b0;
    hostAddr = 2'h0;
    hostDataIn = 8'h00;
  end
  // write a byte, even into a full buffer
  task automatic put(input logic [1:0] a, input logic [7:0] d);
    hostAddr <= a;
    hostDataIn <= d;
    @(posedge sys_clk);
    hostWrite <= 1'b1;
    repeat (4) @(posedge sys_clk);
    hostWrite <= 1'b0;
    hostAddr <= ~a;
    hostDataIn <= ~d;
    repeat (2) @(posedge sys_clk);
  endtask
  // take a byte, even from an empty buffer
  task automatic get(input logic [1:0] a, output logic [7:0] d);
    hostAddr <= a;
    @(posedge sys_clk);
    hostRead <= 1'b1;
    repeat (4) @(posedge sys_clk);
    d = hostDataOut;
    hostRead <= 1'b0;
    hostAddr <= ~a;
    repeat (2) @(posedge sys_clk);
  endtask
endmodule // ppbs_host_model
`default_nettype wire

// file: sim/tb.sv
// tb: register bus and host pin scenarios for ppbs_top
// assumes ppbs_host_model as host and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ppbs_pkg::*;
  logic sys_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, irq;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic hostWrite, hostRead;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, hostAddr, bSeen, rSeen;
  logic [7:0] hostDataIn, hostDataOut, hb;
  int err_total = 0;
  int checks_done = 0;
  always #4 sys_clk = ~sys_clk;
  ppbs_top u_dut (.sys_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .hostWrite, .hostRead, .hostAddr, .hostDataIn, .hostDataOut, .irq);
  ppbs_host_model u_host (.sys_clk, .hostWrite, .hostRead, .hostAddr, .hostDataIn, .hostDataOut);
  function automatic logic [31:0] st(input logic [3:0] f, input logic o, input logic [3:0] e,
    input logic u);
    return {16'h0000, &f, o, 2'b00, f, &e, u, 2'b00, e};
  endfunction
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 50)
    begin
      err_total++;
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        bSeen = s_axi_bresp;
        break;
      end
    end
    tmo(n);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic chkrd(input logic [7:0] a, input logic [31:0] e);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rSeen = s_axi_rresp;
        break;
      end
    end
    tmo(n);
    chk(s_axi_rdata, e);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial
  begin
    {sys_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chkrd(OFF_BUFFER_STATUS, st(4'h0, 1'b0, 4'hF, 1'b0));
    chk({30'h0, rSeen}, {30'h0, RESP_OKAY});
    wr(OFF_BUFFER_STATUS, 32'hFFFF_FFFF);
    chk({30'h0, bSeen}, {30'h0, RESP_OKAY});
    chkrd(OFF_BUFFER_STATUS, st(4'h0, 1'b0, 4'hF, 1'b0));
    for (int i = 0; i < 4; i++)
    begin
      u_host.put(2'(i), 8'(8'hA0 + i));
      chkrd(OFF_BUFFER_STATUS, st(4'(2 ** (i + 1) - 1), 1'b0, 4'hF, 1'b0));
    end
    u_host.put(2'h2, 8'h5A);
    chkrd(OFF_BUFFER_STATUS, st(4'hF, 1'b1, 4'hF, 1'b0));
    for (int i = 0; i < 4; i++)
    begin
      chkrd(8'(OFF_IN_DATA0 + 4 * i), 32'(8'hA0 + i));
      chkrd(OFF_BUFFER_STATUS, st(4'(4'hF << (i + 1)), 1'b1, 4'hF, 1'b0));
    end
    wr(OFF_BUFFER_STATUS, 32'h0000_0000);
    chkrd(OFF_BUFFER_STATUS, st(4'h0, 1'b0, 4'hF, 1'b0));
    for (int i = 0; i < 4; i++)
    begin
      wr(8'(OFF_OUT_DATA0 + 4 * i), 32'(8'h50 + i));
      chkrd(OFF_BUFFER_STATUS, st(4'h0, 1'b0, 4'(4'hF << (i + 1)), 1'b0));
    end
    for (int i = 0; i < 4; i++)
    begin
      u_host.get(2'(i), hb);
      chk({24'h000000, hb}, 32'(8'h50 + i));
      chkrd(OFF_BUFFER_STATUS, st(4'h0, 1'b0, 4'(2 ** (i + 1) - 1), 1'b0));
    end
    wr(OFF_IRQ_MASK, 32'h0000_0002);
    chkrd(OFF_IRQ_STATUS, 32'h0000_000D);
    chk({31'h0, irq}, 32'h0);
    u_host.get(2'h1, hb);
    chkrd(OFF_BUFFER_STATUS, st(4'h0, 1'b0, 4'hF, 1'b1));
    chk({31'h0, irq}, 32'h1);
    chkrd(OFF_IRQ_STATUS, 32'h0000_000A);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_BUFFER_STATUS, 32'h0000_0000);
    chkrd(OFF_BUFFER_STATUS, st(4'h0, 1'b0, 4'hF, 1'b0));
    wr(OFF_CONTROL, 32'h0000_0000);
    u_host.put(2'h0, 8'h11);
    u_host.get(2'h3, hb);
    chkrd(OFF_BUFFER_STATUS, st(4'h0, 1'b0, 4'hF, 1'b0));
    wr(OFF_CONTROL, 32'h0000_0001);
    chkrd(8'h40, 32'h0000_0000);
    chk({30'h0, rSeen}, {30'h0, RESP_SLVERR});
    wr(8'h40, 32'h0000_0001);
    chk({30'h0, bSeen}, {30'h0, RESP_SLVERR});
    close_out();
  end
endmodule // tb
`default_nettype wire
